/* File: ssa_acq_regs.vh */
// Register map and constants of the acquisition controller
// Assumes a single 20 MHz system clock and a plain register port
`ifndef SSA_ACQ_REGS_VH
`define SSA_ACQ_REGS_VH
`define SSA_NCH 4
`define SSA_DW 16
`define SSA_AW 8
`define SSA_FIFO_DEPTH 16
`define SSA_PTR_W 4
`define SSA_LVL_W 5
`define SSA_BLOCK 5'h08
// Offsets
`define SSA_CTRL 8'h00
`define SSA_MODE 8'h04
`define SSA_DIV 8'h08
`define SSA_COUNT 8'h0C
`define SSA_CHCFG 8'h10
`define SSA_STATUS 8'h14
`define SSA_IRQ_STAT 8'h18
`define SSA_IRQ_MASK 8'h1C
`define SSA_DATA0 8'h20
`define SSA_SCOUNT 8'h30
// Control bits (write pulses except calibrate)
`define SSA_C_START 0
`define SSA_C_STOP 1
`define SSA_C_CONV 2
`define SSA_C_CAL 3
// Mode bits
`define SSA_M_HW 0
`define SSA_M_FINITE 1
`define SSA_M_EXTCLK 2
`define SSA_M_BUF 3
`define SSA_M_STEN 4
`define SSA_M_REFEN 5
`define SSA_M_STANA 6
`define SSA_M_REFANA 7
// Interrupt bits
`define SSA_I_OVF 0
`define SSA_I_DONE 1
`define SSA_I_BLOCK 2
// Selector codes
`define SSA_SEL_SIG 2'h0
`define SSA_SEL_CAL 2'h1
`define SSA_SEL_GND 2'h2
// Reset values
`define SSA_MODE_RST 8'h00
`define SSA_DIV_RST 16'h0014
`define SSA_COUNT_RST 16'h0001
`define SSA_CHCFG_RST 16'h0000
`endif

/* File: ssa_acq.v */
// Simultaneous-sampling acquisition controller: per-channel selector,
// gain, converter pacing, per-channel FIFOs, DMA and register readout.
// Assumes all inputs synchronous to clk_sys; converters answer with one
// done pulse carrying all channel results at once.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`include "ssa_acq_regs.vh"
module ssa_acq
(
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Register port
  input wire [`SSA_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Converters, all channels at once
  output reg conv_start,
  input wire conv_done,
  input wire [`SSA_NCH*`SSA_DW-1:0] conv_data,
  // Front end per channel
  output reg [2*`SSA_NCH-1:0] sel_code,
  output reg [2*`SSA_NCH-1:0] gain_code,
  // Timing and triggers
  input wire ext_sample_clk,
  input wire start_trig_dig,
  input wire start_trig_ana,
  input wire ref_trig_dig,
  input wire ref_trig_ana,
  // DMA
  output wire dma_req,
  input wire dma_ack,
  output reg [`SSA_NCH*`SSA_DW-1:0] dma_data,
  // Interrupt
  output wire irq
);

  localparam ST_IDLE = 3'b001;
  localparam ST_ARM = 3'b010;
  localparam ST_RUN = 3'b100;

  function [1:0] ssa_gain;
    input [1:0] range;
    begin
      // Smallest range gets the largest gain
      ssa_gain = 2'h3 - range;
    end
  endfunction

  function ssa_wr_hit;
    input [`SSA_AW-1:0] a;
    input [`SSA_AW-1:0] off;
    begin
      ssa_wr_hit = reg_wr && (a == off);
    end
  endfunction

  reg [2:0] state_reg;
  reg [7:0] mode_reg;
  reg [15:0] div_reg;
  reg [15:0] count_reg;
  reg [15:0] chcfg_reg;
  reg cal_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg [15:0] div_cnt_reg;
  reg ext_clk_d_reg;
  reg conv_busy_reg;
  reg [3:0] conv_pend_reg;
  reg ref_seen_reg;
  reg [15:0] samp_cnt_reg;
  reg [`SSA_PTR_W-1:0] wr_ptr_reg;
  reg [`SSA_PTR_W-1:0] rd_ptr_reg;
  reg [`SSA_LVL_W-1:0] level_reg;
  reg block_d_reg;
  reg [`SSA_DW-1:0] fifo_mem [0:`SSA_NCH*`SSA_FIFO_DEPTH-1];

  wire hw_mode = mode_reg[`SSA_M_HW];
  wire finite = mode_reg[`SSA_M_FINITE];
  wire buffered = mode_reg[`SSA_M_BUF];
  wire wr_ctrl = ssa_wr_hit(reg_addr, `SSA_CTRL);
  wire cmd_start = wr_ctrl && reg_wdata[`SSA_C_START];
  wire cmd_stop = wr_ctrl && reg_wdata[`SSA_C_STOP];
  wire cmd_conv = wr_ctrl && reg_wdata[`SSA_C_CONV];
  wire start_trig = mode_reg[`SSA_M_STANA] ? start_trig_ana : start_trig_dig;
  wire ref_trig = mode_reg[`SSA_M_REFANA] ? ref_trig_ana : ref_trig_dig;
  wire ref_use = mode_reg[`SSA_M_REFEN] && finite && hw_mode;
  wire full = (level_reg == `SSA_FIFO_DEPTH);
  wire empty = (level_reg == 5'h00);
  // Last channel data register pops one sample set
  wire pio_pop = reg_rd && (reg_addr == (`SSA_DATA0 + 8'h0C)) && !empty;
  wire dma_pop = dma_ack && !empty;
  wire pop = pio_pop || dma_pop;
  wire push = conv_done && (state_reg == ST_RUN);
  wire block_rdy = (level_reg >= `SSA_BLOCK);
  wire int_tick = (div_cnt_reg == 16'h0000);
  wire ext_tick = ext_sample_clk && !ext_clk_d_reg;
  wire pace = mode_reg[`SSA_M_EXTCLK] ? ext_tick : int_tick;
  wire count_hit = finite && (!ref_use || ref_seen_reg) && push &&
                   (samp_cnt_reg + 16'h0001 >= count_reg);
  wire ovf_evt = push && full;
  wire done_evt = count_hit;
  wire block_evt = block_rdy && !block_d_reg;
  // Software launch when the converter is free and a command waits
  wire sw_launch = (state_reg == ST_RUN) && !conv_busy_reg && !conv_start && !hw_mode &&
                   (conv_pend_reg != 4'h0 || cmd_conv);

  // Block request while a block is waiting
  assign dma_req = hw_mode && buffered && block_rdy;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  integer i;

  // Front end: selector and gain per channel
  always @*
  begin
    for (i = 0; i < `SSA_NCH; i = i + 1)
    begin
      if (cal_reg)
        sel_code[2*i +: 2] = `SSA_SEL_CAL;
      else if (chcfg_reg[4*i])
        sel_code[2*i +: 2] = `SSA_SEL_GND;
      else
        sel_code[2*i +: 2] = `SSA_SEL_SIG;
      gain_code[2*i +: 2] = ssa_gain(chcfg_reg[4*i+1 +: 2]);
    end
  end

  // Configuration registers
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mode_reg <= `SSA_MODE_RST;
      div_reg <= `SSA_DIV_RST;
      count_reg <= `SSA_COUNT_RST;
      chcfg_reg <= `SSA_CHCFG_RST;
      cal_reg <= 1'b0;
      irq_mask_reg <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        cal_reg <= reg_wdata[`SSA_C_CAL];
      // Mode is frozen while acquiring to avoid half-switched timing
      if (ssa_wr_hit(reg_addr, `SSA_MODE) && state_reg == ST_IDLE)
        mode_reg <= reg_wdata[7:0];
      if (ssa_wr_hit(reg_addr, `SSA_DIV))
        div_reg <= reg_wdata[15:0];
      if (ssa_wr_hit(reg_addr, `SSA_COUNT))
        count_reg <= reg_wdata[15:0];
      if (ssa_wr_hit(reg_addr, `SSA_CHCFG))
        chcfg_reg <= reg_wdata[15:0];
      if (ssa_wr_hit(reg_addr, `SSA_IRQ_MASK))
        irq_mask_reg <= reg_wdata[2:0];
    end
  end

  // Acquisition sequencer
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      ref_seen_reg <= 1'b0;
      samp_cnt_reg <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (cmd_start)
          begin
            ref_seen_reg <= 1'b0;
            samp_cnt_reg <= 16'h0000;
            if (hw_mode && mode_reg[`SSA_M_STEN])
              state_reg <= ST_ARM;
            else
              state_reg <= ST_RUN;
          end
        end
        ST_ARM:
        begin
          if (cmd_stop)
            state_reg <= ST_IDLE;
          else if (start_trig)
            state_reg <= ST_RUN;
        end
        ST_RUN:
        begin
          if (ref_use && ref_trig)
            ref_seen_reg <= 1'b1;
          if (push && finite && (!ref_use || ref_seen_reg))
            samp_cnt_reg <= samp_cnt_reg + 16'h0001;
          // Only a stop ends continuous runs
          if (cmd_stop)
            state_reg <= ST_IDLE;
          else if (count_hit)
            state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Conversion launch
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      div_cnt_reg <= 16'h0000;
      ext_clk_d_reg <= 1'b0;
      conv_start <= 1'b0;
      conv_busy_reg <= 1'b0;
      conv_pend_reg <= 1'b0;
    end
    else
    begin
      ext_clk_d_reg <= ext_sample_clk;
      if (int_tick || state_reg != ST_RUN)
        div_cnt_reg <= div_reg;
      else
        div_cnt_reg <= div_cnt_reg - 16'h0001;
      conv_start <= 1'b0;
      if (conv_done)
        conv_busy_reg <= 1'b0;
      if (state_reg != ST_RUN)
        conv_pend_reg <= 4'h0;
      // Commands are counted up to 15 pending, none merged, until the converter is free
      else if (!hw_mode && cmd_conv && !sw_launch && conv_pend_reg != 4'hF)
        conv_pend_reg <= conv_pend_reg + 4'h1;
      else if (!cmd_conv && sw_launch)
        conv_pend_reg <= conv_pend_reg - 4'h1;
      if (state_reg == ST_RUN && !conv_busy_reg && !conv_start)
      begin
        if (hw_mode && pace)
        begin
          conv_start <= 1'b1;
          conv_busy_reg <= 1'b1;
        end
        else if (sw_launch)
        begin
          conv_start <= 1'b1;
          conv_busy_reg <= 1'b1;
        end
      end
    end
  end

  // Per-channel FIFOs sharing one pointer pair keep channels aligned
  always @(posedge clk_sys)
  begin
    if (push)
    begin
      for (i = 0; i < `SSA_NCH; i = i + 1)
        fifo_mem[i*`SSA_FIFO_DEPTH + wr_ptr_reg] <= conv_data[i*`SSA_DW +: `SSA_DW];
    end
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      level_reg <= 5'h00;
      dma_data <= 64'h0000000000000000;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      if (push && full)
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      else if (pop)
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      if (push && !full && !pop)
        level_reg <= level_reg + 5'h01;
      else if (pop && !push)
        level_reg <= level_reg - 5'h01;
      if (dma_pop)
      begin
        for (i = 0; i < `SSA_NCH; i = i + 1)
          dma_data[i*`SSA_DW +: `SSA_DW] <= fifo_mem[i*`SSA_FIFO_DEPTH + rd_ptr_reg];
      end
    end
  end

  // Sticky events: set wins over write-one-to-clear
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_stat_reg <= 3'h0;
      block_d_reg <= 1'b0;
    end
    else
    begin
      block_d_reg <= block_rdy;
      if (ssa_wr_hit(reg_addr, `SSA_IRQ_STAT))
        irq_stat_reg <= irq_stat_reg & ~reg_wdata[2:0];
      if (cmd_start && state_reg == ST_IDLE)
        irq_stat_reg[`SSA_I_OVF] <= 1'b0;
      if (ovf_evt)
        irq_stat_reg[`SSA_I_OVF] <= 1'b1;
      if (done_evt)
        irq_stat_reg[`SSA_I_DONE] <= 1'b1;
      if (block_evt)
        irq_stat_reg[`SSA_I_BLOCK] <= 1'b1;
    end
  end

  // Register read, data in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SSA_CTRL: reg_rdata <= {28'h0000000, cal_reg, 3'h0};
        `SSA_MODE: reg_rdata <= {24'h000000, mode_reg};
        `SSA_DIV: reg_rdata <= {16'h0000, div_reg};
        `SSA_COUNT: reg_rdata <= {16'h0000, count_reg};
        `SSA_CHCFG: reg_rdata <= {16'h0000, chcfg_reg};
        `SSA_STATUS: reg_rdata <= {21'h000000, level_reg, ref_seen_reg,
                                   conv_busy_reg, full, state_reg};
        `SSA_IRQ_STAT: reg_rdata <= {29'h00000000, irq_stat_reg};
        `SSA_IRQ_MASK: reg_rdata <= {29'h00000000, irq_mask_reg};
        `SSA_SCOUNT: reg_rdata <= {16'h0000, samp_cnt_reg};
        // Direct single-sample read of the FIFO head
        `SSA_DATA0, `SSA_DATA0 + 8'h04, `SSA_DATA0 + 8'h08, `SSA_DATA0 + 8'h0C:
          reg_rdata <= empty ? 32'h00000000 :
            {16'h0000, fifo_mem[reg_addr[3:2]*`SSA_FIFO_DEPTH + rd_ptr_reg]};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
      reg_rdata <= 32'h00000000;
  end

endmodule // ssa_acq

/* File: ssa_conv_model.sv */
// Converter bank model on the far side of the controller
// Assumes one-cycle conv_start pulses on clk_sys
module ssa_conv_model
(
  // Clock and reset
  input logic clk_sys,
  input logic sys_rst,
  // Converter port
  input logic conv_start,
  input logic [3:0] lat,
  output logic conv_done,
  output logic [63:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_reg;
  logic [11:0] seq_reg;
  always @(posedge clk_sys)
  begin
    conv_done <= 1'b0;
    // Data bus is not held after the done pulse
    conv_data <= ~conv_data;
    if (sys_rst)
    begin
      cnt_reg <= 5'h00;
      seq_reg <= 12'h001;
      conv_data <= 64'h0;
    end
    else if (conv_start)
      cnt_reg <= {1'b0, lat} + 5'h01;
    else if (cnt_reg == 5'h01)
    begin
      cnt_reg <= 5'h00;
      conv_done <= 1'b1;
      conv_data <= {seq_reg, 4'h3, seq_reg, 4'h2, seq_reg, 4'h1, seq_reg, 4'h0};
      seq_reg <= seq_reg + 12'h001;
    end
    else if (cnt_reg != 5'h00)
      cnt_reg <= cnt_reg - 5'h01;
  end
endmodule // ssa_conv_model

/* File: ssa_acq_props.sv */
// Port checker for the acquisition controller
// Assumes clk_sys with synchronous active-high sys_rst
`include "ssa_acq_regs.vh"
module ssa_acq_props
(
  // Clock and reset
  input logic clk_sys,
  input logic sys_rst,
  // Register port
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  // Converter, front end, DMA, interrupt
  input logic conv_start,
  input logic conv_done,
  input logic [7:0] sel_code,
  input logic [7:0] gain_code,
  input logic dma_ack,
  input logic dma_req,
  input logic [63:0] dma_data,
  input logic irq
);
  logic busy_reg;
  logic [31:0] wd_reg;
  wire cfg_wr = reg_wr && reg_addr == `SSA_CHCFG;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  always @(posedge clk_sys)
  begin
    wd_reg <= reg_wdata;
    if (sys_rst)
      busy_reg <= 1'b0;
    else if (conv_start)
      busy_reg <= 1'b1;
    else if (conv_done)
      busy_reg <= 1'b0;
  end
  rdata_zero_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside answer cycle");
  conv_busy_a: assert property (conv_start |-> !busy_reg)
    else $error("conversion launched while busy");
  rst_front_a: assert property ($past(sys_rst) |-> sel_code == 8'h00 && gain_code == 8'hFF)
    else $error("front end not at reset state");
  cal_sel_a: assert property (reg_wr && reg_addr == `SSA_CTRL && reg_wdata[`SSA_C_CAL]
    |=> sel_code == 8'h55)
    else $error("calibration did not switch selectors");
  gain_map_a: assert property (cfg_wr |=> gain_code[1:0] == 2'h3 - wd_reg[2:1]
    && gain_code[7:6] == 2'h3 - wd_reg[14:13])
    else $error("gain does not match range");
  gnd_sel_a: assert property (cfg_wr && sel_code != 8'h55
    |=> sel_code[1:0] == (wd_reg[0] ? `SSA_SEL_GND : `SSA_SEL_SIG))
    else $error("ground selection wrong");
  dma_hold_a: assert property (!dma_ack |=> $stable(dma_data))
    else $error("dma data changed without pop");
  irq_mask_a: assert property (reg_wr && reg_addr == `SSA_IRQ_MASK && reg_wdata[2:0] == 3'h0
    |=> !irq)
    else $error("masked interrupt still high");
  conv_c: cover property (conv_start);
  pop_c: cover property (dma_req && dma_ack);
  irq_c: cover property (irq);
endmodule // ssa_acq_props
bind ssa_acq ssa_acq_props u_props (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .conv_start, .conv_done, .sel_code, .gain_code, .dma_ack, .dma_req,
  .dma_data, .irq);

/* File: testbench.sv */
// Self-checking bench for the acquisition controller
// Assumes ssa_conv_model as the converter bank
`include "ssa_acq_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic dma_ack = 1'b0;
  logic ext_sample_clk = 1'b0;
  logic start_trig_dig = 1'b0;
  logic ref_trig_dig = 1'b0;
  logic [3:0] lat = 4'h2;
  logic [31:0] reg_rdata;
  logic [63:0] conv_data;
  logic [63:0] dma_data;
  logic [7:0] sel_code;
  logic [7:0] gain_code;
  logic conv_start;
  logic conv_done;
  logic dma_req;
  logic irq;
  int n_fail = 0;
  int n_compared = 0;
  int n_conv = 0;
  int cycles = 0;
  ssa_acq DUT (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv_start, .conv_done, .conv_data, .sel_code, .gain_code, .ext_sample_clk,
    .start_trig_dig, .start_trig_ana(1'b0), .ref_trig_dig, .ref_trig_ana(1'b0),
    .dma_req, .dma_ack, .dma_data, .irq);
  ssa_conv_model u_conv (.clk_sys, .sys_rst, .conv_start, .lat, .conv_done, .conv_data);
  initial
    forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (conv_start === 1'b1)
      n_conv++;
    if (cycles == 6000)
    begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata & m);
  endtask
  task automatic t_reset();
    rd(`SSA_MODE, 32'hFF, 32'h00, "mode");
    rd(`SSA_DIV, 32'hFFFF, 32'h14, "div");
    rd(`SSA_COUNT, 32'hFFFF, 32'h01, "count");
    rd(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk("sel", 8'h00, sel_code);
    chk("gain", 8'hFF, gain_code);
  endtask
  task automatic t_sw();
    lat = 4'h6;
    n_conv = 0;
    wr(`SSA_CTRL, 32'h1);
    wr(`SSA_CTRL, 32'h4);
    wr(`SSA_CTRL, 32'h4);
    wr(`SSA_CTRL, 32'h4);
    repeat (40) @(posedge clk_sys);
    chk("conversions", 3, n_conv);
    rd(`SSA_STATUS, 32'h7C0, 32'hC0, "level");
    rd(`SSA_DATA0, 32'hFFFF, 32'h10, "ch0");
    rd(8'h2C, 32'hFFFF, 32'h13, "ch3");
    rd(`SSA_STATUS, 32'h7C0, 32'h80, "popped");
    wr(`SSA_CTRL, 32'h2);
  endtask
  task automatic t_front();
    wr(`SSA_CTRL, 32'h8);
    chk("cal sel", 8'h55, sel_code);
    wr(`SSA_CTRL, 32'h0);
    wr(`SSA_CHCFG, 32'h25);
    chk("gnd sel", 8'h02, sel_code);
    chk("gain", 8'hF9, gain_code);
    wr(`SSA_CHCFG, 32'h0);
  endtask
  task automatic t_trig();
    lat = 4'h2;
    wr(`SSA_MODE, 32'h35);
    wr(`SSA_CTRL, 32'h1);
    rd(`SSA_STATUS, 32'h7, 32'h2, "armed");
    n_conv = 0;
    ref_trig_dig <= 1'b1;
    @(posedge clk_sys);
    start_trig_dig <= 1'b1;
    repeat (4) @(posedge clk_sys);
    start_trig_dig <= 1'b0;
    ref_trig_dig <= 1'b0;
    rd(`SSA_STATUS, 32'h27, 32'h04, "run no ref");
    repeat (2)
    begin
      ext_sample_clk <= 1'b1;
      repeat (8) @(posedge clk_sys);
      ext_sample_clk <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
    chk("ext conversions", 2, n_conv);
    wr(`SSA_CTRL, 32'h2);
  endtask
  task automatic t_finite();
    wr(`SSA_MODE, 32'h03);
    wr(`SSA_DIV, 32'h3);
    wr(`SSA_COUNT, 32'h3);
    wr(`SSA_IRQ_MASK, 32'h2);
    n_conv = 0;
    wr(`SSA_CTRL, 32'h1);
    for (int i = 0; i < 200 && irq !== 1'b1; i++)
      @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    chk("finite conversions", 3, n_conv);
    rd(`SSA_SCOUNT, 32'hFFFF, 32'h3, "scount");
    rd(`SSA_STATUS, 32'h7, 32'h1, "idle");
    wr(`SSA_IRQ_STAT, 32'h2);
    chk("done irq clear", 1'b0, irq);
  endtask
  task automatic t_ovf();
    lat = 4'h0;
    wr(`SSA_MODE, 32'h09);
    wr(`SSA_IRQ_MASK, 32'h1);
    wr(`SSA_CTRL, 32'h1);
    for (int i = 0; i < 300 && irq !== 1'b1; i++)
      @(posedge clk_sys);
    chk("dma req", 1'b1, dma_req);
    wr(`SSA_IRQ_MASK, 32'h0);
    chk("irq masked", 1'b0, irq);
    wr(`SSA_IRQ_MASK, 32'h1);
    chk("irq unmasked", 1'b1, irq);
    wr(`SSA_CTRL, 32'h2);
    rd(`SSA_IRQ_STAT, 32'h1, 32'h1, "ovf kept");
    rd(`SSA_STATUS, 32'h7C8, 32'h408, "full");
    @(posedge clk_sys);
    dma_ack <= 1'b1;
    @(posedge clk_sys);
    dma_ack <= 1'b0;
    rd(`SSA_STATUS, 32'h7C0, 32'h3C0, "dma pop");
    chk("dma ch0 tag", 32'h0, dma_data[3:0]);
    chk("dma ch3", {dma_data[15:4], 4'h3}, dma_data[63:48]);
    wr(`SSA_IRQ_STAT, 32'h1);
    chk("ovf clear", 1'b0, irq);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_sw();
    t_front();
    t_trig();
    t_finite();
    t_ovf();
    results();
  end
endmodule // testbench
